// [sarc_regs.svh]
`ifndef SARC_REGS_SVH
`define SARC_REGS_SVH

// Result width and the one-hot trial masks at its ends.
`define SARC_BITS 12
`define SARC_MSB_MASK 12'h800
`define SARC_LSB_MASK 12'h001
`define SARC_CODE_ZERO 12'h000

// Reset levels of the synchronised pins {bipolar, pd_n, rd_n, cs_n, st_n}.
`define SARC_PIN_RESET 5'h0f

// Clock period and the documented times in nanoseconds.
`define SARC_CLK_NS 50
`define SARC_ACQ_NS 160
`define SARC_WAKE_NS 350

// Least times round up to whole clock cycles.
`define SARC_ACQ_CYCLES ((`SARC_ACQ_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_WAKE_CYCLES ((`SARC_WAKE_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)

// Cycles from the launch cycle to the return of the idle state.
`define SARC_CONV_CYCLES 27

`endif

// [sarc_pkg.sv]
package sarc_pkg;

    // Phases of one conversion.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD,
        ST_TRIAL,
        ST_DECIDE,
        ST_LOAD
    } sarc_state_type;

endpackage : sarc_pkg

// [sarc_sync.sv]
`timescale 1ns/1ps

module sarc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Asynchronous levels and their synchronised copies.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Two flip-flops per bit; only the second stage is visible outside.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : sarc_sync

// [sarc_sequencer.sv]
`timescale 1ns/1ps
`include "sarc_regs.svh"

// Functional notes
// - A conversion launches only on start request with chip select low.
// - The approximation register is cleared before the first bit trial.
// - Start requests during a conversion are ignored; no abort or restart.
// - Trial bits drive the 12-bit DAC one at a time, MSB first.
// - Each bit decision comes from the comparator output.
// - Acquire phase: input to sampling capacitor, feedback switch closed.
// - Convert phase: feedback switch open, capacitor grounded before trials.
// - At conversion end all 12 bits load into the output latches.
// - Unipolar output is straight binary, one step is full scale/4096.
// - Bipolar output is two's complement.
// - Code transitions sit halfway between integer steps.
// - Busy is low for the whole conversion, high once it completes.
// - Start and read strobes are ignored unless chip select is low.
// - While power-down is low a falling start launches nothing.
// - Data drivers are enabled only while read and chip select are low.

module sarc_sequencer
    import sarc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Host control pins.
    input wire logic start_request_n_in,
    input wire logic chip_select_n_in,
    input wire logic read_n_in,
    input wire logic power_down_n_in,
    input wire logic bipolar_mode_in,
    // Analog front end.
    input wire logic comparator_in,
    output logic sample_switch_out,
    output logic feedback_switch_out,
    output logic cap_ground_out,
    output logic [`SARC_BITS-1:0] dac_trial_out,
    // Host data and status.
    output logic busy_n_out,
    output logic [`SARC_BITS-1:0] data_out,
    output logic data_oe_out
);

    logic [4:0] pins_raw;
    logic [4:0] pins_s;
    logic start_n_s;
    logic cs_n_s;
    logic rd_n_s;
    logic pd_n_s;
    logic bipolar_s;

    sarc_state_type state_q;
    sarc_state_type state_d;
    logic [`SARC_BITS-1:0] approximation_register_q;
    logic [`SARC_BITS-1:0] approximation_register_d;
    logic [`SARC_BITS-1:0] mask_q;
    logic [`SARC_BITS-1:0] mask_d;
    logic [`SARC_BITS-1:0] latch_q;
    logic [`SARC_BITS-1:0] latch_d;
    logic [`SARC_BITS-1:0] kept;
    logic bipolar_q;
    logic bipolar_d;
    logic start_prev_q;
    logic start_prev_d;
    logic oe_q;
    logic oe_d;
    logic [3:0] wake_q;
    logic [3:0] wake_d;
    logic start_fall;
    logic launch;

    // Every host pin is asynchronous to the sequencer clock, so all of
    // them pass the two-stage synchroniser before any logic reads them.
    assign pins_raw = {bipolar_mode_in, power_down_n_in, read_n_in,
                       chip_select_n_in, start_request_n_in};

    sarc_sync #(
        .WIDTH(5),
        .RESET_VAL(`SARC_PIN_RESET)
    ) u_pin_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    assign start_n_s = pins_s[0];
    assign cs_n_s = pins_s[1];
    assign rd_n_s = pins_s[2];
    assign pd_n_s = pins_s[3];
    assign bipolar_s = pins_s[4];

    // A start is the falling edge of the request, seen only with chip
    // select low, power up, wake-up time elapsed and no conversion running.
    // A request that falls while busy is dropped, not queued for later.
    assign start_fall = start_prev_q & ~start_n_s;
    assign launch = start_fall & ~cs_n_s
        & pd_n_s
        & (wake_q == 4'h0)
        & (state_q == ST_IDLE);

    // Next values of the conversion sequence and the output latches.
    always_comb begin
        state_d = state_q;
        approximation_register_d = approximation_register_q;
        mask_d = mask_q;
        latch_d = latch_q;
        bipolar_d = bipolar_q;
        kept = approximation_register_q;
        unique case (state_q)
            ST_IDLE: begin
                if (launch) begin
                    state_d = ST_HOLD;
                    approximation_register_d = `SARC_CODE_ZERO;
                    mask_d = `SARC_MSB_MASK;
                    bipolar_d = bipolar_s;
                end
            end
            ST_HOLD: begin
                // Set the MSB for the first trial.
                approximation_register_d = approximation_register_q | mask_q;
                state_d = ST_TRIAL;
            end
            ST_TRIAL: begin
                // One cycle for the DAC charge to settle on the comparator.
                state_d = ST_DECIDE;
            end
            ST_DECIDE: begin
                // Keep the bit when the held input exceeds the DAC level.
                // The half-step offset of the transitions is built into
                // the analog DAC, so the logic keeps the straight code.
                if (comparator_in) begin
                    kept = approximation_register_q;
                end else begin
                    kept = approximation_register_q & ~mask_q;
                end
                mask_d = mask_q >> 1;
                approximation_register_d = kept | (mask_q >> 1);
                if (mask_q == `SARC_LSB_MASK) begin
                    state_d = ST_LOAD;
                end else begin
                    state_d = ST_TRIAL;
                end
            end
            ST_LOAD: begin
                // Offset binary becomes two's complement by flipping the MSB.
                if (bipolar_q) begin
                    latch_d = approximation_register_q
                        ^ `SARC_MSB_MASK;
                end else begin
                    latch_d = approximation_register_q;
                end
                state_d = ST_IDLE;
            end
        endcase
    end

    // Next values of the pin trackers; the wake-up count restarts every
    // cycle power-down is low so a start is held off after waking.
    always_comb begin
        start_prev_d = start_n_s;
        oe_d = ~rd_n_s & ~cs_n_s;
        wake_d = wake_q;
        if (!pd_n_s) begin
            wake_d = 4'(`SARC_WAKE_CYCLES);
        end else if (wake_q != 4'h0) begin
            wake_d = wake_q - 4'h1;
        end
    end

    // Registers of the sequence.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            approximation_register_q <= `SARC_CODE_ZERO;
            mask_q <= `SARC_CODE_ZERO;
            latch_q <= `SARC_CODE_ZERO;
            bipolar_q <= 1'b0;
        end else begin
            state_q <= state_d;
            approximation_register_q <= approximation_register_d;
            mask_q <= mask_d;
            latch_q <= latch_d;
            bipolar_q <= bipolar_d;
        end
    end

    // Registers of the pin trackers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start_prev_q <= 1'b1;
            oe_q <= 1'b0;
            wake_q <= 4'h0;
        end else begin
            start_prev_q <= start_prev_d;
            oe_q <= oe_d;
            wake_q <= wake_d;
        end
    end

    // Switch controls follow the phase: sampling and offset nulling while
    // idle, grounded capacitor and open feedback from the hold cycle on.
    assign sample_switch_out = (state_q == ST_IDLE);
    assign feedback_switch_out = (state_q == ST_IDLE);
    assign cap_ground_out = (state_q != ST_IDLE);
    assign dac_trial_out = approximation_register_q;
    assign busy_n_out = (state_q == ST_IDLE);
    assign data_out = latch_q;
    assign data_oe_out = oe_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Nothing but a gated falling start leaves the idle state.
    a_start_gating: assert property (
        (state_q == ST_IDLE) && !(start_fall && !cs_n_s)
        |=> state_q == ST_IDLE)
        else $error("conversion left idle without a gated start");

    // The register is empty in the hold cycle before any trial.
    a_clear_first: assert property (
        (state_q == ST_HOLD) |-> approximation_register_q == 12'h000)
        else $error("register not cleared before first trial");

    // A running conversion always runs to its full length.
    a_no_restart: assert property (
        launch |-> ##1 !busy_n_out [*8] ##18 !busy_n_out ##1 busy_n_out)
        else $error("conversion length not 26 busy cycles");

    // The first trial presents only the MSB.
    a_msb_first: assert property (
        (state_q == ST_HOLD) |=> dac_trial_out == 12'h800)
        else $error("first trial is not the MSB alone");

    // A low comparator clears the bit under trial.
    a_bit_clear: assert property (
        (state_q == ST_DECIDE) && !comparator_in
        |=> (approximation_register_q & $past(mask_q)) == 12'h000)
        else $error("rejected bit was kept");

    // A high comparator keeps the bit under trial.
    a_bit_keep: assert property (
        (state_q == ST_DECIDE) && comparator_in
        |=> (approximation_register_q & $past(mask_q)) == $past(mask_q))
        else $error("accepted bit was dropped");

    // Switch settings for the convert phase.
    a_switch_phase: assert property (
        (state_q != ST_IDLE)
        |-> cap_ground_out && !feedback_switch_out && !sample_switch_out)
        else $error("convert phase switches wrong");

    // The load cycle copies the result in the selected format.
    a_result_load: assert property (
        (state_q == ST_LOAD)
        |=> data_out == (bipolar_q ? ($past(approximation_register_q)
            ^ 12'h800) : $past(approximation_register_q)))
        else $error("result latch wrong after load");

    // The latches change only at the end of a conversion.
    a_latch_hold: assert property (
        (state_q != ST_LOAD) |=> $stable(data_out))
        else $error("output latch changed outside load");

    // Power-down blocks every launch: an idle sequencer stays idle.
    a_pd_block: assert property (
        !pd_n_s && (state_q == ST_IDLE) |=> state_q == ST_IDLE)
        else $error("launch during power-down");

    // Drivers enable only after read and chip select were both low.
    a_oe_gate: assert property (
        data_oe_out |-> !$past(rd_n_s) && !$past(cs_n_s))
        else $error("data drivers enabled without read and select");

    // Acquire settings stand whenever no conversion runs.
    a_idle_acquire: assert property (
        busy_n_out |-> sample_switch_out && feedback_switch_out
            && !cap_ground_out)
        else $error("acquire phase switches wrong");

    // Twelve decisions: the load follows the decision on the LSB.
    a_twelve_trials: assert property (
        (state_q == ST_LOAD) |-> $past(state_q) == ST_DECIDE
            && $past(mask_q) == `SARC_LSB_MASK)
        else $error("load did not follow the LSB decision");

    // Busy stays low through the load and rises right after it.
    a_busy_release: assert property (
        (state_q == ST_LOAD) |-> !busy_n_out ##1 busy_n_out)
        else $error("busy did not rise after the load");

    // Main scenarios.
    c_unipolar_done: cover property (
        (state_q == ST_LOAD) && !bipolar_q ##1 busy_n_out);
    c_bipolar_done: cover property (
        (state_q == ST_LOAD) && bipolar_q ##1 busy_n_out);
    c_start_ignored: cover property (
        !busy_n_out && start_fall && !cs_n_s);
    c_read_result: cover property (
        (state_q == ST_LOAD) ##[1:20] data_oe_out);

endmodule : sarc_sequencer

// [sarc_afe_model.sv]
`timescale 1ns/1ps
`include "sarc_regs.svh"

// Analog front end seen as codes: a held level compared with the DAC code.
module sarc_afe_model (
    // Clock.
    input wire logic clk_in,
    // Level as a code, sampling switch and DAC trial code.
    input wire logic [`SARC_BITS-1:0] level_in,
    input wire logic sample_switch_in,
    input wire logic [`SARC_BITS-1:0] dac_trial_in,
    // Comparator decision.
    output logic comparator_out
);
    logic [`SARC_BITS-1:0] held_q;

    // Track only while the switch is closed, so later level changes are lost.
    always_ff @(posedge clk_in) begin
        if (sample_switch_in) begin
            held_q <= level_in;
        end
    end

    // A code stands for the middle of its step, so equal counts as above.
    assign comparator_out = (held_q >= dac_trial_in);
endmodule : sarc_afe_model

// [sar_conversion_sequencer_test.sv]
`timescale 1ns/1ps
`include "sarc_regs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t: got %h exp %h", $time, a, b); end end

module sar_conversion_sequencer_test;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic st_n = 1'b1, cs_n = 1'b0, rd_n = 1'b1, pd_n = 1'b1, bip = 1'b0;
    logic cmp, samp, fb, capg, busy_n, oe;
    logic [11:0] level = 12'h000;
    logic [11:0] dac, data;
    logic [31:0] seed = 32'hcc7c;
    int bad_count = 0;
    int n_checks = 0;

    sarc_sequencer sarc_sequencer_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .start_request_n_in(st_n), .chip_select_n_in(cs_n),
        .read_n_in(rd_n), .power_down_n_in(pd_n), .bipolar_mode_in(bip),
        .comparator_in(cmp), .sample_switch_out(samp),
        .feedback_switch_out(fb), .cap_ground_out(capg),
        .dac_trial_out(dac), .busy_n_out(busy_n), .data_out(data),
        .data_oe_out(oe)
    );

    sarc_afe_model sarc_afe_model_inst (
        .clk_in(clk_in), .level_in(level), .sample_switch_in(samp),
        .dac_trial_in(dac), .comparator_out(cmp)
    );

    // Clock of 50 ns period.
    initial begin
        forever #25 clk_in = ~clk_in;
    end

    // Straight code, or two's complement with the sign bit turned round.
    function automatic logic [11:0] expect_code(input logic [11:0] v,
                                                input logic b);
        return b ? {~v[11], v[10:0]} : v;
    endfunction : expect_code

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // One conversion; a second start fall inside it must change nothing.
    task automatic convert(input logic [11:0] lvl, input logic b,
                           input logic again);
        logic [11:0] prev;
        int n;
        prev = data;
        @(posedge clk_in);
        level <= lvl;
        bip <= b;
        st_n <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (busy_n !== 1'b0 && n < 8);
        `CHK(busy_n, 1'b0)
        `CHK(dac, 12'h000)
        `CHK({samp, fb, capg}, 3'b001)
        `CHK(data, prev)
        n = 1;
        while (busy_n === 1'b0 && n < 40) begin
            @(posedge clk_in);
            st_n <= !(again && n == 4);
            #1;
            if (n == 1) `CHK(dac, 12'h800)
            n++;
        end
        `CHK(n, `SARC_CONV_CYCLES)
        `CHK(data, expect_code(lvl, b))
        `CHK({samp, fb, capg}, 3'b110)
        // Spacing keeps acquire time and start rate inside host limits.
        repeat (8) @(posedge clk_in);
    endtask : convert

    // A start fall that must be dropped, then a wake-up pause.
    task automatic no_start(input logic cs, input logic pd);
        @(posedge clk_in);
        cs_n <= cs;
        pd_n <= pd;
        st_n <= 1'b0;
        repeat (10) begin
            @(posedge clk_in);
            #1;
            `CHK(busy_n, 1'b1)
        end
        @(posedge clk_in);
        st_n <= 1'b1;
        cs_n <= 1'b0;
        pd_n <= 1'b1;
        repeat (12) @(posedge clk_in);
    endtask : no_start

    task automatic read_chk(input logic cs);
        @(posedge clk_in);
        rd_n <= 1'b0;
        cs_n <= cs;
        repeat (3) @(posedge clk_in);
        #1;
        `CHK(oe, !cs)
        @(posedge clk_in);
        rd_n <= 1'b1;
        cs_n <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        `CHK(oe, 1'b0)
    endtask : read_chk

    // Watchdog well beyond the expected run of about 840 cycles.
    initial begin
        #(50 * 20000);
        bad_count++;
        complete_run();
    end

    // Main sequence: reset, corner codes, refusals, then random codes.
    initial begin
        repeat (15) @(posedge clk_in);
        #1;
        `CHK({samp, fb, capg, busy_n, oe}, 5'b11010)
        `CHK(data, 12'h000)
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        read_chk(1'b0);
        read_chk(1'b1);
        convert(12'hfff, 1'b0, 1'b0);
        convert(12'h000, 1'b0, 1'b1);
        convert(12'h800, 1'b1, 1'b0);
        convert(12'h7ff, 1'b1, 1'b1);
        no_start(1'b1, 1'b1);
        no_start(1'b0, 1'b0);
        repeat (16) begin
            seed = lfsr_next(seed);
            convert(seed[11:0], seed[12], seed[13]);
        end
        complete_run();
    end
endmodule : sar_conversion_sequencer_test
